/* core/rfsc_top.sv */
// Operation
// - Pulse calibration-off bit for one clock
// - Calibration busy bit follows synthesizer calibration
// - Frame engine state shown in bits 5:0
// - Data-present bit high, low during overflow
// - Packet-ready when filtered bytes exceed threshold
// - Packet-ready when a complete frame present
// - Read leaving fewer than threshold clears it
// - Packet-ready held high during overflow
// - Transmit: delimiter sent sets, frame end clears
// - Receive: delimiter received sets, frame end clears
// - Live clear-channel in bit 4 and pin
// - Latched clear-channel updated on strobes only
// - Lock bit follows PLL lock
// - Transmit and receive activity bits
// - Seven-bit threshold, reset 0x40, bit7 zero
// - Acknowledge exactly twelve symbols after frame
// - Slotted: first slot boundary past twelve
// - Optional twelve-symbol receive turnaround timeout
// - Signed threshold: clear when RSSI below
// - Decision select picks clear-channel rule
// - Energy decision with hysteresis, holds between
`timescale 1ns/1ps
module rfsc_top
   import rfsc_pkg::*;
#(
   parameter int ACK_CYC = ACK_DELAY_CYC,
   parameter int SLT_CYC = SLOT_CYC
)
(
   input  wire logic           sys_clk,       // Core clock
   input  wire logic           nrst,          // Synchronous reset, active low
   input  wire rfsc_spi_pins_t spi_pins,      // Serial port pins from host
   output logic                spi_miso,      // Serial data to host
   output logic                spi_miso_oe,   // Drive enable for spi_miso
   input  wire rfsc_radio_in_t radio,         // Radio core status and events
   output logic                cca_pin,       // Live clear-channel output
   output logic                ack_tx_start,  // Pulse: send acknowledge now
   output logic                rx_turn_busy   // Receive turnaround timeout
);

   if (ACK_CYC < 2 || SLT_CYC < 2)
   begin : g_chk
      $error("rfsc_top: delay counts too small");
   end

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed
   {
      logic       sclk_prev;
      logic [4:0] cnt;
      logic [6:0] shin;
      logic [6:0] addr;
      logic       wr;
      logic [7:0] shout;
      logic       miso;
      logic       oe;
      logic [6:0] rdy_thr;
      logic [1:0] options;
      logic [7:0] clr_thr;
      logic       cal_off;
      logic       cal_busy;
      logic [5:0] eng_state;
      logic       data_present;
      logic       pkt_ready;
      logic       sfd;
      logic       energy_clear;
      logic       cca;
      logic       latched;
      logic       lock;
      logic       tx;
      logic       rx;
   } rfsc_top_st_t;

   rfsc_top_st_t   st_reg;
   rfsc_top_st_t   st_next;
   rfsc_spi_pins_t pins_s;
   rfsc_spi_pins_t pins_sel;
   rfsc_spi_pins_t pins_q;
   logic           sclk_rise;
   logic [7:0]     cal_word;
   logic [7:0]     event_word;
   logic [7:0]     rd_data;
   logic [7:0]     wr_data;
   logic [6:0]     cmd_addr;
   logic [9:0]     rssi_x;
   logic [9:0]     thr_x;
   logic [9:0]     low_x;
   logic           at_or_above;
   logic           below_low;
   logic           over_thr;
   logic           under_thr;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchroniser and acknowledge timing

   rfsc_sync #(
      .W (3)
   ) u_sync (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .d       (pins_sel),
      .q       (pins_q)
   );

   // Select travels inverted so that the synchroniser's reset reads as deselected
   assign pins_sel = {spi_pins.sclk, spi_pins.mosi, ~spi_pins.cs_n};
   assign pins_s   = {pins_q.sclk, pins_q.mosi, ~pins_q.cs_n};

   rfsc_acktimer #(
      .ACK_CYC (ACK_CYC),
      .SLT_CYC (SLT_CYC)
   ) u_ack (
      .sys_clk     (sys_clk),
      .nrst        (nrst),
      .frame_end   (radio.frame_end),
      .ack_request (radio.ack_request),
      .slotted     (st_reg.options[OPT_SLOT_BIT]),
      .turn_en     (st_reg.options[OPT_TURN_BIT]),
      .ack_start   (ack_tx_start),
      .turn_busy   (rx_turn_busy)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Read view of the registers

   always_comb
   begin
      cal_word               = CAL_STATE_RST;
      cal_word[CAL_OFF_BIT]  = st_reg.cal_off;
      cal_word[CAL_BUSY_BIT] = st_reg.cal_busy;
      cal_word[5:0]          = st_reg.eng_state;
      event_word             = EVENT_RST;
      event_word[DATA_BIT]   = st_reg.data_present;
      event_word[PKT_BIT]    = st_reg.pkt_ready;
      event_word[SFD_BIT]    = st_reg.sfd;
      event_word[CCA_BIT]    = st_reg.cca;
      event_word[LATCH_BIT]  = st_reg.latched;
      event_word[LOCK_BIT]   = st_reg.lock;
      event_word[TX_BIT]     = st_reg.tx;
      event_word[RX_BIT]     = st_reg.rx;
   end

   assign cmd_addr = {st_reg.shin[5:0], pins_s.mosi};
   assign wr_data  = {st_reg.shin, pins_s.mosi};

   always_comb
   begin
      unique case (cmd_addr)
         ADDR_CAL_STATE: rd_data = cal_word;
         ADDR_EVENT:     rd_data = event_word;
         ADDR_RDY_THR:   rd_data = {1'b0, st_reg.rdy_thr};
         ADDR_OPTIONS:   rd_data = {6'h00, st_reg.options};
         ADDR_CLR_THR:   rd_data = st_reg.clr_thr;
         default:        rd_data = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clear-channel energy comparison, signed, with hysteresis

   assign rssi_x      = {{2{radio.rssi[7]}}, radio.rssi};
   assign thr_x       = {{2{st_reg.clr_thr[7]}}, st_reg.clr_thr};
   assign low_x       = thr_x - {7'h00, radio.hysteresis};
   assign at_or_above = $signed(rssi_x) >= $signed(thr_x);
   assign below_low   = $signed(rssi_x) < $signed(low_x);

   // Packet-ready threshold comparisons
   assign over_thr  = radio.rx_filtered > {1'b0, st_reg.rdy_thr};
   assign under_thr = radio.rx_count < {1'b0, st_reg.rdy_thr};

   assign sclk_rise = pins_s.sclk & ~st_reg.sclk_prev;

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      st_next           = st_reg;
      st_next.sclk_prev = pins_s.sclk;

      // Serial port: command byte (write flag, address), then data byte
      if (pins_s.cs_n)
      begin
         st_next.cnt  = '0;
         st_next.oe   = 1'b0;
         st_next.miso = 1'b0;
      end
      else
      begin
         st_next.oe = 1'b1;
         if (sclk_rise && st_reg.cnt < SPI_END_BITS)
         begin
            st_next.cnt  = st_reg.cnt + 5'd1;
            st_next.shin = wr_data[6:0];
            if (st_reg.cnt == SPI_CMD_LAST)
            begin
               st_next.wr    = st_reg.shin[SPI_WR_BIT - 1];
               st_next.addr  = cmd_addr;
               st_next.miso  = rd_data[7];
               st_next.shout = {rd_data[6:0], 1'b0};
            end
            else if (st_reg.cnt > SPI_CMD_LAST)
            begin
               st_next.miso  = st_reg.shout[7];
               st_next.shout = {st_reg.shout[6:0], 1'b0};
               if (st_reg.cnt == SPI_END_BITS - 5'd1 && st_reg.wr)
               begin
                  unique case (st_reg.addr)
                     ADDR_RDY_THR: st_next.rdy_thr = wr_data[6:0];
                     ADDR_OPTIONS: st_next.options = wr_data[1:0];
                     ADDR_CLR_THR: st_next.clr_thr = wr_data;
                     default:      st_next.rdy_thr = st_reg.rdy_thr;
                  endcase
               end
            end
         end
      end

      // Calibration, engine state, PLL lock and activity
      st_next.cal_off   = radio.cal_off;
      st_next.cal_busy  = radio.cal_busy;
      st_next.eng_state = radio.engine_state;
      st_next.lock      = radio.pll_lock;
      st_next.tx        = radio.tx_active;
      st_next.rx        = radio.rx_active;

      // Receive buffer flags
      st_next.data_present = (radio.rx_count != 8'h00) && !radio.rx_overflow;
      if (radio.rx_overflow)
      begin
         st_next.pkt_ready = 1'b1;
      end
      else if (over_thr || radio.rx_frame_done_present)
      begin
         st_next.pkt_ready = 1'b1;
      end
      else if (radio.rx_byte_read && under_thr)
      begin
         st_next.pkt_ready = 1'b0;
      end

      // Start-of-frame: a set in the same cycle as an end wins
      if (radio.tx_sfd || radio.rx_sfd)
      begin
         st_next.sfd = 1'b1;
      end
      else if (radio.tx_done || radio.rx_done)
      begin
         st_next.sfd = 1'b0;
      end

      // Energy decision holds between the two levels
      if (at_or_above)
      begin
         st_next.energy_clear = 1'b0;
      end
      else if (below_low)
      begin
         st_next.energy_clear = 1'b1;
      end

      unique case (radio.clear_decision_select)
         RFSC_CCA_ALWAYS: st_next.cca = 1'b1;
         RFSC_CCA_ENERGY: st_next.cca = st_reg.energy_clear;
         RFSC_CCA_NOT_RX: st_next.cca = !radio.receiving_frame;
         RFSC_CCA_BOTH:   st_next.cca = st_reg.energy_clear && !radio.receiving_frame;
      endcase

      if (radio.strobe_latch || radio.strobe_tx_if_clear)
      begin
         st_next.latched = st_reg.cca;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         st_reg         <= '0;
         st_reg.rdy_thr <= RDY_THR_RST;
         st_reg.options <= OPTIONS_RST;
         st_reg.clr_thr <= CLR_THR_RST;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign spi_miso    = st_reg.miso;
   assign spi_miso_oe = st_reg.oe;
   assign cca_pin     = st_reg.cca;

endmodule : rfsc_top

/* core/rfsc_pkg.sv */
package rfsc_pkg;

   // Clock and symbol timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int SYMBOL_NS     = 16000;
   localparam int SYMBOL_CYC    = (SYMBOL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACK_SYMBOLS   = 12;
   localparam int SLOT_SYMBOLS  = 20;
   localparam int ACK_DELAY_CYC = ACK_SYMBOLS * SYMBOL_CYC;
   localparam int SLOT_CYC      = SLOT_SYMBOLS * SYMBOL_CYC;

   ////////////////////////////////////////////////////////////////////////////
   // Register addresses
   localparam logic [6:0] ADDR_CAL_STATE = 7'h32;
   localparam logic [6:0] ADDR_EVENT     = 7'h33;
   localparam logic [6:0] ADDR_RDY_THR   = 7'h34;
   localparam logic [6:0] ADDR_OPTIONS   = 7'h35;
   localparam logic [6:0] ADDR_CLR_THR   = 7'h36;

   // Reset values
   localparam logic [7:0] CAL_STATE_RST  = 8'h00;
   localparam logic [7:0] EVENT_RST      = 8'h00;
   localparam logic [6:0] RDY_THR_RST    = 7'h40;
   localparam logic [1:0] OPTIONS_RST    = 2'h1;
   localparam logic [7:0] CLR_THR_RST    = 8'he0;

   // Field positions
   localparam int CAL_OFF_BIT  = 7;
   localparam int CAL_BUSY_BIT = 6;
   localparam int DATA_BIT     = 7;
   localparam int PKT_BIT      = 6;
   localparam int SFD_BIT      = 5;
   localparam int CCA_BIT      = 4;
   localparam int LATCH_BIT    = 3;
   localparam int LOCK_BIT     = 2;
   localparam int TX_BIT       = 1;
   localparam int RX_BIT       = 0;
   localparam int OPT_SLOT_BIT = 1;
   localparam int OPT_TURN_BIT = 0;

   // Serial port framing: command byte then data byte
   localparam logic [4:0] SPI_CMD_LAST = 5'd7;
   localparam logic [4:0] SPI_END_BITS = 5'd16;
   localparam int         SPI_WR_BIT   = 7;

   typedef enum logic [1:0]
   {
      RFSC_CCA_ALWAYS = 2'h0,
      RFSC_CCA_ENERGY = 2'h1,
      RFSC_CCA_NOT_RX = 2'h2,
      RFSC_CCA_BOTH   = 2'h3
   } rfsc_clear_decision_select_t;

   typedef struct packed
   {
      logic sclk;
      logic mosi;
      logic cs_n;
   } rfsc_spi_pins_t;

   typedef struct packed
   {
      logic           cal_busy;
      logic           cal_off;
      logic [5:0]     engine_state;
      logic [7:0]     rx_count;
      logic [7:0]     rx_filtered;
      logic           rx_frame_done_present;
      logic           rx_overflow;
      logic           rx_byte_read;
      logic           tx_sfd;
      logic           tx_done;
      logic           rx_sfd;
      logic           rx_done;
      logic           receiving_frame;
      logic           pll_lock;
      logic           tx_active;
      logic           rx_active;
      logic           strobe_latch;
      logic           strobe_tx_if_clear;
      logic [7:0]     rssi;
      logic [2:0]     hysteresis;
      rfsc_clear_decision_select_t clear_decision_select;
      logic           frame_end;
      logic           ack_request;
   } rfsc_radio_in_t;

endpackage : rfsc_pkg

/* core/rfsc_sync.sv */
`timescale 1ns/1ps
module rfsc_sync
   import rfsc_pkg::*;
#(
   parameter int W = 3
)
(
   input  wire logic         sys_clk, // Core clock
   input  wire logic         nrst,    // Synchronous reset, active low
   input  wire logic [W-1:0] d,       // Asynchronous inputs
   output logic      [W-1:0] q        // Filtered, synchronised inputs
);

   if (W < 1)
   begin : g_chk
      $error("rfsc_sync: W must be at least 1");
   end

   typedef struct packed
   {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } rfsc_sync_st_t;

   rfsc_sync_st_t st_reg;
   rfsc_sync_st_t st_next;

   always_comb
   begin
      st_next    = st_reg;
      st_next.s1 = d;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      // A change counts once the second and third stages agree
      for (int i = 0; i < W; i++)
      begin
         if (st_reg.s2[i] == st_reg.s3[i])
         begin
            st_next.q[i] = st_reg.s3[i];
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign q = st_reg.q;

endmodule : rfsc_sync

/* core/rfsc_acktimer.sv */
`timescale 1ns/1ps
module rfsc_acktimer
   import rfsc_pkg::*;
#(
   parameter int ACK_CYC = ACK_DELAY_CYC,
   parameter int SLT_CYC = SLOT_CYC
)
(
   input  wire logic sys_clk,     // Core clock
   input  wire logic nrst,        // Synchronous reset, active low
   input  wire logic frame_end,   // Pulse: received frame ended
   input  wire logic ack_request, // Ended frame asks for an acknowledge
   input  wire logic slotted,     // Acknowledge on backoff slot boundary
   input  wire logic turn_en,     // Apply receive turnaround timeout
   output logic      ack_start,   // Pulse: start acknowledge frame
   output logic      turn_busy    // Turnaround timeout running
);

   localparam int CW = $clog2(ACK_CYC + 1) + 1;
   localparam int SW = $clog2(SLT_CYC + 1);

   if (ACK_CYC < 2 || SLT_CYC < 2)
   begin : g_chk
      $error("rfsc_acktimer: delays must be at least two cycles");
   end

   localparam logic [CW-1:0] ACK_LAST = CW'(ACK_CYC - 1);
   localparam logic [CW-1:0] ACK_FULL = CW'(ACK_CYC);
   localparam logic [SW-1:0] SLT_LAST = SW'(SLT_CYC - 1);

   typedef struct packed
   {
      logic [CW-1:0] dly;
      logic          run;
      logic          pend;
      logic [SW-1:0] slot;
      logic          ack;
      logic          busy;
   } rfsc_ack_st_t;

   rfsc_ack_st_t st_reg;
   rfsc_ack_st_t st_next;

   always_comb
   begin
      st_next     = st_reg;
      st_next.ack = 1'b0;
      // Free-running backoff slot grid
      st_next.slot = (st_reg.slot == SLT_LAST) ? '0 : st_reg.slot + SW'(1);
      if (frame_end)
      begin
         st_next.dly  = '0;
         st_next.run  = 1'b1;
         st_next.pend = ack_request;
         st_next.busy = turn_en;
      end
      else if (st_reg.run)
      begin
         if (st_reg.dly != ACK_FULL)
         begin
            st_next.dly = st_reg.dly + CW'(1);
         end
         if (st_reg.dly == ACK_LAST)
         begin
            st_next.busy = 1'b0;
            if (!slotted && st_reg.pend)
            begin
               st_next.ack  = 1'b1;
               st_next.pend = 1'b0;
            end
         end
         if (slotted && st_reg.pend && st_reg.dly == ACK_FULL && st_reg.slot == SLT_LAST)
         begin
            st_next.ack  = 1'b1;
            st_next.pend = 1'b0;
         end
         if (!st_reg.pend && st_reg.dly == ACK_FULL)
         begin
            st_next.run = 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign ack_start = st_reg.ack;
   assign turn_busy = st_reg.busy;

endmodule : rfsc_acktimer

/* verification/rfsc_checker.sv */
`timescale 1ns/1ps
module rfsc_checker
   import rfsc_pkg::*;
#(
   parameter int ACK_CYC = ACK_DELAY_CYC,
   parameter int SLT_CYC = SLOT_CYC
)
(
   input wire logic           sys_clk,      // Core clock
   input wire logic           nrst,         // Synchronous reset, active low
   input wire rfsc_spi_pins_t spi_pins,     // Serial pins from host
   input wire logic           spi_miso,     // Serial data to host
   input wire logic           spi_miso_oe,  // Drive enable for spi_miso
   input wire rfsc_radio_in_t radio,        // Radio status and events
   input wire logic           cca_pin,      // Live clear-channel output
   input wire logic           ack_tx_start, // Acknowledge start pulse
   input wire logic           rx_turn_busy  // Turnaround timeout running
);
   int   since;
   logic armed;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);
   // Cycles since the last frame end, zero before the first one
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         since <= 0;
         armed <= 1'b0;
      end
      else if (radio.frame_end)
      begin
         since <= 1;
         armed <= radio.ack_request;
      end
      else if (since != 0 && since < 1000000)
         since <= since + 1;
   end
   ////////////////////////////////////////
   AST_ACK_WINDOW: assert property (ack_tx_start |-> armed && since >= ACK_CYC + 1
      && since <= ACK_CYC + SLT_CYC + 1) else $error("ack start outside its window");
   AST_ACK_ONE: assert property (ack_tx_start |=> !ack_tx_start [*4])
      else $error("ack start longer than one cycle");
   AST_TURN_WINDOW: assert property (rx_turn_busy |-> since >= 1 && since <= ACK_CYC)
      else $error("turnaround busy outside its window");
   AST_TURN_RISE: assert property ($rose(rx_turn_busy) |-> since == 1)
      else $error("turnaround busy rose late");
   AST_CCA_ALWAYS: assert property ((radio.clear_decision_select == RFSC_CCA_ALWAYS) [*4] |=> cca_pin)
      else $error("clear channel low in always mode");
   AST_CCA_RXBUSY: assert property ((radio.clear_decision_select[1] && radio.receiving_frame) [*4]
      |=> !cca_pin) else $error("clear channel high while receiving");
   AST_CCA_RXFREE: assert property ((radio.clear_decision_select == RFSC_CCA_NOT_RX
      && !radio.receiving_frame) [*4] |=> cca_pin) else $error("clear channel low when idle");
   AST_CCA_ENERGY: assert property ((radio.clear_decision_select[0] && radio.rssi == 8'h7f) [*4]
      |=> !cca_pin) else $error("clear channel high at full energy");
   AST_OE_IDLE: assert property (spi_pins.cs_n [*6] |-> !spi_miso_oe && !spi_miso)
      else $error("serial output driven while deselected");
   AST_OE_SEL: assert property (!spi_pins.cs_n [*6] |-> spi_miso_oe)
      else $error("serial output not driven while selected");
endmodule : rfsc_checker

bind rfsc_top rfsc_checker #(.ACK_CYC(ACK_CYC), .SLT_CYC(SLT_CYC)) u_chk (.sys_clk(sys_clk),
   .nrst(nrst), .spi_pins(spi_pins), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
   .radio(radio), .cca_pin(cca_pin), .ack_tx_start(ack_tx_start), .rx_turn_busy(rx_turn_busy));

/* verification/rfsc_host.sv */
`timescale 1ns/1ps
module rfsc_host
   import rfsc_pkg::*;
(
   input  wire logic     sys_clk, // Core clock, only to start a frame
   output rfsc_spi_pins_t pins,    // Serial pins to device
   input  wire logic     miso,    // Serial data from device
   output logic [7:0]    rd_data, // Last byte read
   output int            rd_cnt   // Completed reads
);
   initial
   begin
      pins    = '{sclk: 1'b0, mosi: 1'b0, cs_n: 1'b1};
      rd_data = 8'h00;
      rd_cnt  = 0;
   end
   // Command byte then data byte, MSB first, link clock only inside the frame
   task xfer(input logic [7:0] cmd, input logic [7:0] wd);
      logic [15:0] sh;
      logic [7:0]  r;
      sh = {cmd, wd};
      r  = 8'h00;
      @(posedge sys_clk);
      #1;
      pins.cs_n = 1'b0;
      for (int i = 15; i >= 0; i--)
      begin
         pins.mosi = sh[i];
         #80;
         pins.sclk = 1'b1;
         r = {r[6:0], miso};
         #80;
         pins.sclk = 1'b0;
      end
      #80;
      pins.cs_n = 1'b1;
      pins.mosi = ~pins.mosi;
      #200;
      if (!cmd[7])
      begin
         rd_data = r;
         rd_cnt  = rd_cnt + 1;
      end
   endtask : xfer
endmodule : rfsc_host

/* verification/rfsc_top_tb.sv */
`timescale 1ns/1ps
module rfsc_top_tb
   import rfsc_pkg::*;
;
   localparam int ACK = 24;
   localparam int SLT = 40;
   localparam logic [20:0] PKT_TAB [8] = '{{8'd5, 8'd5, 5'b00010}, {8'd6, 8'd6, 5'b00011},
      {8'd5, 8'd0, 5'b00111}, {8'd4, 8'd0, 5'b00110}, {8'd4, 8'd0, 5'b10011},
      {8'd1, 8'd0, 5'b00110}, {8'd1, 8'd0, 5'b01001}, {8'd0, 8'd0, 5'b00100}};
   localparam logic [4:0] SFD_TAB [4] = '{5'b10001, 5'b01000, 5'b00111, 5'b00010};
   localparam logic [14:0] CCA_TAB [10] = '{{3'b000, 8'h7f, 4'b1011}, {3'b111, 8'h7f, 4'b0001},
      {3'b111, 8'h7f, 4'b0100}, {3'b100, 8'h7f, 4'b0010}, {3'b010, 8'h7f, 4'b0000},
      {3'b010, 8'hf5, 4'b0010}, {3'b010, 8'hf6, 4'b0010}, {3'b010, 8'hf8, 4'b0000},
      {3'b010, 8'hf7, 4'b0000}, {3'b110, 8'hec, 4'b0010}};
   typedef struct {int fe; bit slot;} rfsc_ack_note_t;
   logic           sys_clk, nrst, spi_miso, spi_miso_oe, cca_pin, ack_tx_start, rx_turn_busy;
   rfsc_spi_pins_t spi_pins;
   rfsc_radio_in_t radio;
   logic [7:0]     host_rd, v, rd_q[$];
   int             host_cnt, seed, num_errors = 0, compares = 0, cyc = 0, slot_ref = -1;
   rfsc_ack_note_t ack_q[$];
   rfsc_top #(.ACK_CYC(ACK), .SLT_CYC(SLT)) u_dut (.sys_clk(sys_clk), .nrst(nrst),
      .spi_pins(spi_pins), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .radio(radio),
      .cca_pin(cca_pin), .ack_tx_start(ack_tx_start), .rx_turn_busy(rx_turn_busy));
   rfsc_host u_host (.sys_clk(sys_clk), .pins(spi_pins), .miso(spi_miso), .rd_data(host_rd),
      .rd_cnt(host_cnt));
   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////
   task step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : step
   task chk8(input string what, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e)
      begin
         $display("unexpected %s: expected %h, seen %h", what, e, g);
         num_errors++;
      end
   endtask : chk8
   task chk_int(input string what, input int e, input int g);
      compares++;
      if (g != e)
      begin
         $display("unexpected %s: expected %0d, seen %0d", what, e, g);
         num_errors++;
      end
   endtask : chk_int
   task rd(input logic [6:0] a, input logic [7:0] e);
      rd_q.push_back(e);
      u_host.xfer({1'b0, a}, 8'h00);
      step(1);
   endtask : rd
   task wr(input logic [6:0] a, input logic [7:0] d);
      u_host.xfer({1'b1, a}, d);
      step(1);
   endtask : wr
   task fe(input bit req, input bit note, input bit slot);
      radio.frame_end   = 1'b1;
      radio.ack_request = req;
      if (note)
         ack_q.push_back('{cyc + 1, slot});
      step(1);
      radio.frame_end   = 1'b0;
      radio.ack_request = 1'b0;
   endtask : fe
   task end_of_test;
      $display("errors %0d, compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_of_test
   // Each finished read takes the oldest expected byte
   always @(host_cnt)
      chk8("read data", (rd_q.size() > 0) ? rd_q.pop_front() : 8'hxx, host_rd);
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (ack_tx_start === 1'b1)
         ack_seen();
   end
   task ack_seen;
      rfsc_ack_note_t n;
      int             e;
      n = '{-1000, 1'b0};
      if (ack_q.size() > 0)
         n = ack_q.pop_front();
      e = ACK;
      if (n.slot && slot_ref < 0)
         e = (cyc - n.fe > ACK && cyc - n.fe <= ACK + SLT) ? cyc - n.fe : ACK + 1;
      else if (n.slot)
         e = ((n.fe + ACK + SLT - slot_ref) / SLT) * SLT + slot_ref - n.fe;
      if (n.slot)
         slot_ref = cyc;
      chk_int("ack delay", e, cyc - n.fe);
   endtask : ack_seen
   initial
   begin
      repeat (40000) @(posedge sys_clk);
      $display("unexpected run length: expected below 40000 cycles, seen more");
      num_errors++;
      end_of_test();
   end
   ////////////////////////////////////////
   initial
   begin
      nrst  = 1'b0;
      radio = '0;
      radio.clear_decision_select   = RFSC_CCA_ENERGY;
      radio.rssi       = 8'h7f;
      radio.hysteresis = 3'h2;
      seed = $urandom(32'h69b4);
      step(8);
      nrst = 1'b1;
      step(4);
      rd(ADDR_CAL_STATE, CAL_STATE_RST);
      rd(ADDR_EVENT, EVENT_RST);
      rd(ADDR_RDY_THR, {1'b0, RDY_THR_RST});
      rd(ADDR_OPTIONS, {6'h00, OPTIONS_RST});
      rd(ADDR_CLR_THR, CLR_THR_RST);
      rd(7'h10, 8'h00);
      wr(ADDR_RDY_THR, 8'hff);
      rd(ADDR_RDY_THR, 8'h7f);
      wr(ADDR_OPTIONS, 8'hff);
      rd(ADDR_OPTIONS, 8'h03);
      wr(ADDR_CAL_STATE, 8'hff);
      rd(ADDR_CAL_STATE, 8'h00);
      v = 8'($urandom);
      wr(ADDR_CLR_THR, v);
      rd(ADDR_CLR_THR, v);
      for (int i = 0; i < 4; i++)
      begin
         v = 8'($urandom);
         {radio.cal_busy, radio.engine_state} = {i[0], v[5:0]};
         {radio.pll_lock, radio.tx_active, radio.rx_active, radio.cal_off} = 4'($urandom);
         step(1);
         radio.cal_off = 1'b0;
         step(3);
         rd(ADDR_CAL_STATE, {1'b0, i[0], v[5:0]});
         rd(ADDR_EVENT, {5'h00, radio.pll_lock, radio.tx_active, radio.rx_active});
      end
      {radio.cal_busy, radio.pll_lock, radio.tx_active, radio.rx_active} = 4'h0;
      wr(ADDR_RDY_THR, 8'h05);
      for (int i = 0; i < 8; i++)
      begin
         {radio.rx_count, radio.rx_filtered, radio.rx_frame_done_present, radio.rx_overflow,
            radio.rx_byte_read} = PKT_TAB[i][20:2];
         step(1);
         radio.rx_byte_read = 1'b0;
         step(3);
         rd(ADDR_EVENT, {PKT_TAB[i][1:0], 6'h00});
      end
      for (int i = 0; i < 4; i++)
      begin
         {radio.tx_sfd, radio.tx_done, radio.rx_sfd, radio.rx_done} = SFD_TAB[i][4:1];
         step(1);
         {radio.tx_sfd, radio.tx_done, radio.rx_sfd, radio.rx_done} = 4'h0;
         step(3);
         rd(ADDR_EVENT, {2'b00, SFD_TAB[i][0], 5'h00});
      end
      wr(ADDR_CLR_THR, 8'hf8);
      for (int i = 0; i < 10; i++)
      begin
         radio.clear_decision_select = rfsc_clear_decision_select_t'(CCA_TAB[i][14:13]);
         {radio.receiving_frame, radio.rssi} = CCA_TAB[i][12:4];
         step(6);
         {radio.strobe_latch, radio.strobe_tx_if_clear} = CCA_TAB[i][3:2];
         step(1);
         {radio.strobe_latch, radio.strobe_tx_if_clear} = 2'b00;
         step(3);
         chk8("cca_pin", {7'h00, CCA_TAB[i][1]}, {7'h00, cca_pin});
         rd(ADDR_EVENT, {3'h0, CCA_TAB[i][1:0], 3'h0});
      end
      wr(ADDR_OPTIONS, 8'h01);
      fe(1'b1, 1'b1, 1'b0);
      step(3);
      chk8("rx_turn_busy", 8'h01, {7'h00, rx_turn_busy});
      step(ACK + 10);
      fe(1'b1, 1'b0, 1'b0);
      step(10);
      fe(1'b1, 1'b1, 1'b0);
      step(ACK + 10);
      fe(1'b0, 1'b0, 1'b0);
      step(ACK + SLT);
      wr(ADDR_OPTIONS, 8'h00);
      fe(1'b1, 1'b1, 1'b0);
      step(3);
      chk8("rx_turn_busy", 8'h00, {7'h00, rx_turn_busy});
      step(ACK + 10);
      wr(ADDR_OPTIONS, 8'h02);
      for (int i = 0; i < 3; i++)
      begin
         fe(1'b1, 1'b1, 1'b1);
         step(ACK + SLT + 7 + i);
      end
      end_of_test();
   end
endmodule : rfsc_top_tb
